/* File: common/scfp_cfg.svh */
`ifndef SCFP_CFG_SVH
`define SCFP_CFG_SVH
// ==================================================
// frame geometry
`define SCFP_FRAME_BITS 16
`define SCFP_MSB 15
`define SCFP_MIN_CLOCKS 6'h10
`define SCFP_MAX_CLOCKS 6'h20
`define SCFP_CNT_SAT 6'h3f
// ==================================================
// command field encodings, bits 15:14 and 1:0
`define SCFP_OP_WRITE 2'h2
`define SCFP_OP_WRITE_BAD 2'h3
`define SCFP_OP_READ 2'h1
`define SCFP_OP_READ_BAD 2'h0
`define SCFP_READ_TAIL 2'h2
`define SCFP_READ_REPLY_HEAD 2'h2
// ==================================================
// field positions
`define SCFP_TER_BIT 10
`define SCFP_ADDR_HI 13
`define SCFP_ADDR_LO 8
`define SCFP_DATA_HI 7
// ==================================================
// address space, valid map and reset values
`define SCFP_ADDR_W 6
`define SCFP_NUM_REGS 64
`define SCFP_VALID_MASK 64'h0000_0000_0000_0031
`define SCFP_IDX_OUT 6'h00
`define SCFP_IDX_MAPIN0 6'h04
`define SCFP_IDX_MAPIN1 6'h05
`define SCFP_RST_OUT 8'h00
`define SCFP_RST_MAPIN0 8'h04
`define SCFP_RST_MAPIN1 8'h08
// ==================================================
// special replies
`define SCFP_RESET_REPLY 16'h0400
`define SCFP_SYNTAX_REPLY 16'h7fff
`endif

/* File: common/scfp_pkg.sv */
package scfp_pkg;
  typedef enum logic [1:0] {
    SCFP_CMD_DIAG,
    SCFP_CMD_WR,
    SCFP_CMD_RD,
    SCFP_CMD_SYNTAX
  } scfp_cmd_t;
  typedef enum logic {
    SCFP_IDLE,
    SCFP_FRAME
  } scfp_state_t;
endpackage

/* File: hdl/scfp_sync.sv */
module scfp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta;
  // meta is read only by q_out
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule // scfp_sync

/* File: hdl/scfp_top.sv */
`include "scfp_cfg.svh"
// Function
// - reply to a frame is shifted out only during the following frame
// - clock count not multiple of 8, under 16 or over 32 is a transmission fault
// - after reset or software reset the next reply is a fixed frame
// - write starting 11 or read starting 00 gives the syntax reply
// - access to an unmapped register address gives the syntax reply
// - write is 10, address fields, data; answered by standard diagnosis
// - read is 01, address, tail 10; reply 10, address echo, content
// - diagnosis command answered by diagnosis word with msb zero
// - frame is accepted and acted on only at chip select rising edge
// - fault flag clears on 16, 24 or 32 clocks, sets on failed transfer
// - first reply after reset has fault flag set, later replies normal
module scfp_top
  import scfp_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic SW_RESET_IN,
  // serial link pins
  input wire logic SCLK_IN,
  input wire logic CSN_IN,
  input wire logic SI_IN,
  output logic SO_OUT,
  output logic SO_OE_OUT,
  // device status and control
  input wire logic [15:0] DIAG_IN,
  output logic [7:0] OUT_CTRL_OUT,
  output logic FRAME_DONE_OUT
);
  // ==================================================
  // pin synchronisers
  logic sclk_s;
  logic csn_s;
  logic si_s;
  logic sclk_prev;
  logic csn_prev;
  logic rst_n;

  // software reset behaves like a full reset of the command layer
  assign rst_n = RESETN_IN & ~SW_RESET_IN;

  scfp_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .clk_in(CLK_SYS_IN),
    .resetn_in(RESETN_IN),
    .d_in(SCLK_IN),
    .q_out(sclk_s)
  );
  scfp_sync #(.RST_VAL(1'b1)) u_sync_csn (
    .clk_in(CLK_SYS_IN),
    .resetn_in(RESETN_IN),
    .d_in(CSN_IN),
    .q_out(csn_s)
  );
  scfp_sync #(.RST_VAL(1'b0)) u_sync_si (
    .clk_in(CLK_SYS_IN),
    .resetn_in(RESETN_IN),
    .d_in(SI_IN),
    .q_out(si_s)
  );

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      sclk_prev <= 1'b0;
      csn_prev <= 1'b1;
    end else begin
      sclk_prev <= sclk_s;
      csn_prev <= csn_s;
    end
  end

  // ==================================================
  // edge decode
  wire csn_fall = csn_prev & ~csn_s;
  wire csn_rise = ~csn_prev & csn_s;
  wire sclk_fall = sclk_prev & ~sclk_s;

  // ==================================================
  // frame state
  scfp_state_t state;
  scfp_state_t next_state;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [15:0] reply_hold;
  logic [5:0] bit_count;
  logic [7:0] regs [`SCFP_NUM_REGS];

  always_comb begin
    next_state = state;
    case (state)
      SCFP_IDLE: begin
        if (csn_fall) begin
          next_state = SCFP_FRAME;
        end
      end
      SCFP_FRAME: begin
        if (csn_rise) begin
          next_state = SCFP_IDLE;
        end
      end
      default: begin
        next_state = SCFP_IDLE;
      end
    endcase
  end

  wire in_frame = (state == SCFP_FRAME);
  wire frame_end = in_frame & csn_rise;
  wire shift_edge = in_frame & sclk_fall;

  // ==================================================
  // frame length check
  wire count_ok = (bit_count >= `SCFP_MIN_CLOCKS) && (bit_count <= `SCFP_MAX_CLOCKS) &&
                  (bit_count[2:0] == 3'h0);
  // combinational so the reply latched at frame end reports the frame just closed
  wire transfer_fault_flag = ~count_ok;

  // ==================================================
  // command decode
  wire [1:0] op_head = rx_shift[`SCFP_MSB:`SCFP_MSB-1];
  wire [1:0] op_tail = rx_shift[1:0];
  wire [5:0] reg_addr = rx_shift[`SCFP_ADDR_HI:`SCFP_ADDR_LO];
  wire [3:0] reg_addr_high_field = reg_addr[5:2];
  wire [1:0] reg_addr_low_field = reg_addr[1:0];
  wire [7:0] reg_wdata = rx_shift[`SCFP_DATA_HI:0];
  wire [63:0] valid_mask = `SCFP_VALID_MASK;
  wire addr_ok = valid_mask[reg_addr];
  wire is_write_head = (op_head == `SCFP_OP_WRITE) || (op_head == `SCFP_OP_WRITE_BAD);
  wire is_read_tail = (op_tail == `SCFP_READ_TAIL);
  scfp_cmd_t cmd;

  always_comb begin
    cmd = SCFP_CMD_DIAG;
    if (op_head == `SCFP_OP_WRITE_BAD) begin
      cmd = SCFP_CMD_SYNTAX;
    end else if (is_write_head) begin
      cmd = addr_ok ? SCFP_CMD_WR : SCFP_CMD_SYNTAX;
    end else if (is_read_tail && (op_head == `SCFP_OP_READ_BAD)) begin
      cmd = SCFP_CMD_SYNTAX;
    end else if (is_read_tail) begin
      cmd = addr_ok ? SCFP_CMD_RD : SCFP_CMD_SYNTAX;
    end else begin
      cmd = SCFP_CMD_DIAG;
    end
  end

  // ==================================================
  // reply selection
  // the flag in the word reports the frame just closed
  wire [15:0] diag_word = {1'b0, DIAG_IN[14:11], transfer_fault_flag,
                           DIAG_IN[9:0]};
  wire [15:0] read_word = {`SCFP_READ_REPLY_HEAD, reg_addr_high_field, reg_addr_low_field,
                           regs[reg_addr]};
  logic [15:0] next_reply;

  always_comb begin
    next_reply = diag_word;
    if (!count_ok) begin
      next_reply = diag_word;
    end else begin
      case (cmd)
        SCFP_CMD_WR: next_reply = diag_word;
        SCFP_CMD_RD: next_reply = read_word;
        SCFP_CMD_SYNTAX: next_reply = `SCFP_SYNTAX_REPLY;
        default: next_reply = diag_word;
      endcase
    end
  end

  wire do_write = frame_end & count_ok & (cmd == SCFP_CMD_WR);

  // ==================================================
  // shift registers and counters
  always_ff @(posedge CLK_SYS_IN) begin
    if (!rst_n) begin
      state <= SCFP_IDLE;
      bit_count <= 6'h00;
      rx_shift <= 16'h0000;
    end else begin
      state <= next_state;
      if (csn_fall) begin
        bit_count <= 6'h00;
      end else if (shift_edge && (bit_count != `SCFP_CNT_SAT)) begin
        bit_count <= bit_count + 6'h01;
      end
      // only the last sixteen bits of a longer frame are kept
      if (shift_edge) begin
        rx_shift <= {rx_shift[14:0], si_s};
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!rst_n) begin
      tx_shift <= 16'h0000;
    end else if (csn_fall) begin
      tx_shift <= reply_hold;
    end else if (shift_edge) begin
      // data moves after host sampled on the same falling edge
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!rst_n) begin
      reply_hold <= `SCFP_RESET_REPLY;
    end else if (frame_end) begin
      reply_hold <= next_reply;
    end
  end

  // ==================================================
  // register bank
  always_ff @(posedge CLK_SYS_IN) begin
    if (!rst_n) begin
      for (int i = 0; i < `SCFP_NUM_REGS; i++) begin
        regs[i[5:0]] <= 8'h00;
      end
      regs[`SCFP_IDX_OUT] <= `SCFP_RST_OUT;
      regs[`SCFP_IDX_MAPIN0] <= `SCFP_RST_MAPIN0;
      regs[`SCFP_IDX_MAPIN1] <= `SCFP_RST_MAPIN1;
    end else if (do_write) begin
      regs[reg_addr] <= reg_wdata;
    end
  end

  // ==================================================
  // registered outputs
  always_ff @(posedge CLK_SYS_IN) begin
    if (!rst_n) begin
      SO_OUT <= 1'b0;
      SO_OE_OUT <= 1'b0;
      OUT_CTRL_OUT <= `SCFP_RST_OUT;
      FRAME_DONE_OUT <= 1'b0;
    end else begin
      SO_OUT <= csn_fall ? reply_hold[`SCFP_MSB] :
                (shift_edge ? tx_shift[`SCFP_MSB-1] : tx_shift[`SCFP_MSB]);
      SO_OE_OUT <= ~csn_s;
      if (do_write && (reg_addr == `SCFP_IDX_OUT)) begin
        OUT_CTRL_OUT <= reg_wdata;
      end
      FRAME_DONE_OUT <= frame_end;
    end
  end
endmodule // scfp_top

/* File: tb/scfp_monitor.sv */
module scfp_monitor (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic SW_RESET_IN,
  // link pins
  input wire logic SCLK_IN,
  input wire logic CSN_IN,
  input wire logic SI_IN,
  input wire logic SO_OUT,
  input wire logic SO_OE_OUT,
  // status and control
  input wire logic [15:0] DIAG_IN,
  input wire logic [7:0] OUT_CTRL_OUT,
  input wire logic FRAME_DONE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  // ==========
  // cycles since the last serial clock fall
  logic [7:0] since;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN || $fell(SCLK_IN)) since <= 8'h00;
    else if (since != 8'hff) since <= since + 8'h01;
  end
  oe_on_a: assert property (!CSN_IN [*5] |-> SO_OE_OUT) else $error("so not on");
  oe_off_a: assert property (CSN_IN [*5] |-> !SO_OE_OUT) else $error("so not off");
  done_pulse_a: assert property (FRAME_DONE_OUT |=> !FRAME_DONE_OUT)
    else $error("long done");
  frame_done_a: assert property ($rose(CSN_IN) |-> ##[2:4] FRAME_DONE_OUT)
    else $error("no done after frame");
  done_cs_a: assert property (FRAME_DONE_OUT |-> CSN_IN && $past(CSN_IN, 3))
    else $error("done in frame");
  done_oe_a: assert property (FRAME_DONE_OUT |-> !SO_OE_OUT) else $error("oe at done");
  out_hold_a: assert property (!$stable(OUT_CTRL_OUT) |-> FRAME_DONE_OUT
    || $past(SW_RESET_IN) || $past(SW_RESET_IN, 2)) else $error("output changed off frame end");
  so_shift_a: assert property (!$stable(SO_OUT) && SO_OE_OUT && $past(SO_OE_OUT)
    |-> since inside {[1:5]}) else $error("so moved without clock");
  sw_clear_a: assert property ($rose(SW_RESET_IN) |-> ##[1:3] OUT_CTRL_OUT == 8'h00)
    else $error("soft reset kept output");
endmodule // scfp_monitor

bind scfp_top scfp_monitor mon (.CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN),
  .SW_RESET_IN(SW_RESET_IN), .SCLK_IN(SCLK_IN), .CSN_IN(CSN_IN), .SI_IN(SI_IN),
  .SO_OUT(SO_OUT), .SO_OE_OUT(SO_OE_OUT), .DIAG_IN(DIAG_IN), .OUT_CTRL_OUT(OUT_CTRL_OUT),
  .FRAME_DONE_OUT(FRAME_DONE_OUT));

/* File: tb/scfp_host.sv */
module scfp_host (
  // system clock
  input wire logic clk_in,
  // link pins
  input wire logic so_in,
  input wire logic so_oe_in,
  output logic sclk_out,
  output logic csn_out,
  output logic si_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic so_last = 1'b0;
  initial begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    si_out = 1'b0;
  end
  // ==========
  // n clocks of the low n bits of word, msb first; reply is the first 16 bits
  task automatic xfer(input int n, input logic [31:0] word, output logic [15:0] reply);
    int i;
    reply = 16'h0000;
    @(posedge clk_in);
    csn_out <= 1'b0;
    si_out <= word[n-1];
    repeat (8) @(posedge clk_in);
    for (i = n - 1; i >= 0; i--) begin
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      // a released line must not pass for data
      so_last = so_oe_in ? so_in : ~so_last;
      if (i >= n - 16) reply = {reply[14:0], so_last};
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      if (i > 0) si_out <= word[i-1];
    end
    repeat (4) @(posedge clk_in);
    csn_out <= 1'b1;
    si_out <= ~si_out;
    repeat (12) @(posedge clk_in);
  endtask
endmodule // scfp_host

/* File: tb/scfp_top_tb.sv */
module scfp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sw_reset = 1'b0;
  // bits 15 and 10 set to show they are ignored
  logic [15:0] diag = 16'hc5a5;
  logic [15:0] rep;
  int fail_count = 0;
  int check_count = 0;
  wire logic sclk, csn, si, so, so_oe, done;
  wire logic [7:0] out_ctrl;
  initial begin
    forever #10 clk = ~clk;
  end
  scfp_top dut (.CLK_SYS_IN(clk), .RESETN_IN(resetn), .SW_RESET_IN(sw_reset), .SCLK_IN(sclk),
    .CSN_IN(csn), .SI_IN(si), .SO_OUT(so), .SO_OE_OUT(so_oe), .DIAG_IN(diag),
    .OUT_CTRL_OUT(out_ctrl), .FRAME_DONE_OUT(done));
  scfp_host host (.clk_in(clk), .so_in(so), .so_oe_in(so_oe), .sclk_out(sclk), .csn_out(csn),
    .si_out(si));
  // ==========
  // helpers
  function automatic logic [15:0] dw(input logic flag);
    return {1'b0, diag[14:11], flag, diag[9:0]};
  endfunction
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp16({8'h00, got}, {8'h00, exp});
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // scenarios; each reply belongs to the frame before
  task automatic t_reset();
    host.xfer(16, 32'h0000, rep);
    cmp16(rep, 16'h0400);
    host.xfer(16, 32'h0000, rep);
    cmp16(rep, dw(1'b0));
  endtask
  task automatic t_wr_rd();
    host.xfer(16, 32'h80a5, rep);
    cmp16(rep, dw(1'b0));
    host.xfer(16, 32'h40fe, rep);
    cmp16(rep, dw(1'b0));
    cmp8(out_ctrl, 8'ha5);
    host.xfer(16, 32'h4502, rep);
    cmp16(rep, 16'h80a5);
    host.xfer(16, 32'h4402, rep);
    cmp16(rep, 16'h8508);
    host.xfer(16, 32'h0000, rep);
    cmp16(rep, 16'h8404);
  endtask
  task automatic t_syntax();
    logic [15:0] bad [4];
    int i;
    bad = '{16'hc0ff, 16'h0002, 16'h8133, 16'h7c02};
    for (i = 0; i < 5; i++) begin
      host.xfer(16, (i < 4) ? {16'h0000, bad[i]} : 32'h0000, rep);
      if (i > 0) cmp16(rep, 16'h7fff);
    end
    cmp8(out_ctrl, 8'ha5);
  endtask
  task automatic t_fault();
    host.xfer(12, 32'h0aff, rep);
    cmp16(rep, dw(1'b0) >> 4);
    host.xfer(8, 32'h0080, rep);
    cmp16(rep, dw(1'b1) >> 8);
    host.xfer(20, 32'h080ff, rep);
    cmp16(rep, dw(1'b1));
    host.xfer(24, 32'h0000, rep);
    cmp16(rep, dw(1'b1));
    cmp8(out_ctrl, 8'ha5);
    host.xfer(32, 32'h12340000, rep);
    cmp16(rep, dw(1'b0));
    host.xfer(16, 32'h0000, rep);
    cmp16(rep, dw(1'b0));
  endtask
  task automatic t_sw_reset();
    @(posedge clk);
    sw_reset <= 1'b1;
    @(posedge clk);
    sw_reset <= 1'b0;
    repeat (4) @(posedge clk);
    cmp8(out_ctrl, 8'h00);
    host.xfer(16, 32'h0000, rep);
    cmp16(rep, 16'h0400);
  endtask
  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    cmp8(out_ctrl, 8'h00);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_wr_rd();
    t_syntax();
    t_fault();
    t_sw_reset();
    print_verdict();
  end
endmodule // scfp_top_tb
